// ---- verilog/sd_clock_pkg.sv ----
// Purpose: Shared constants and types for the SD card clock gating block.
// Assumes: 32-bit APB register access, one aligned word per register.
// Notes:   Clock-domain timing counts are derived from periods in ns.
package sd_clock_pkg;

  // Register byte offsets
  localparam logic [11:0] CLOCK_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET        = 12'h004;

  // Clock control field positions
  localparam int INT_EN_BIT      = 0;
  localparam int INT_STABLE_BIT  = 1;
  localparam int CARD_EN_BIT     = 2;
  localparam int CARD_STABLE_BIT = 3;
  localparam int FREQ_SEL_LSB    = 8;
  localparam int FREQ_SEL_WIDTH  = 8;

  // Status field positions
  localparam int STATUS_CARD_BIT    = 0;
  localparam int STATUS_PENDING_BIT = 1;

  // Reset values
  localparam logic                      ENABLE_RESET   = 1'b0;
  localparam logic [FREQ_SEL_WIDTH-1:0] FREQ_SEL_RESET = 8'h01;

  // Timing: settle time of the internal clock after it is started
  localparam int SYS_CLK_PERIOD_NS  = 40;
  localparam int BASE_CLK_PERIOD_NS = 80;
  localparam int INT_SETTLE_NS      = 1000;
  localparam int INT_SETTLE_CYCLES  =
    (INT_SETTLE_NS + BASE_CLK_PERIOD_NS - 1) / BASE_CLK_PERIOD_NS;
  // Card clock counts as stable after this many rising edges
  localparam int CARD_SETTLE_EDGES  = 2;

  // Card clock generator states
  typedef enum logic [1:0] {
    CLK_STOPPED,
    CLK_LOW,
    CLK_HIGH
  } clk_state_type;

  // Register decode result
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CONTROL,
    SEL_STATUS
  } reg_sel_type;

endpackage : sd_clock_pkg

// ---- verilog/bit_sync.sv ----
// Purpose: Two-stage synchroniser for independent levels or toggles.
// Assumes: Each bit is a level or a toggle; multi-bit words need a handshake.
// Notes:   The first stage feeds only the second stage.
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // No reset: the chain flushes within two edges
  always_ff @(posedge clk) begin
    meta     <= async_in;
    sync_out <= meta;
  end

endmodule : bit_sync

// ---- verilog/sd_host_clock_gating.sv ----
// Purpose: Internal clock and card clock gating of an SD host, APB registers.
// Assumes: base_clk is the free-running source for the internal and card clock.
// Notes:   Register side runs on sys_clk; clock generator runs on base_clk.
// Notes on behaviour
// - The card clock stable flag reads 1 only once the card clock runs steadily, else 0.
// - Clearing the card clock enable stops the card clock low; it resets to 0.
// - A new divider takes effect only while the card clock generator is stopped and the clock stands low.
// - Loss of the card-inserted flag clears the card clock enable by hardware.
// - Clearing the internal clock enable stops the internal clock; registers stay usable.
// - Setting the internal clock enable starts it and raises its stable flag once settled.
// - Card detection keeps running whatever the internal clock enable says.
module sd_host_clock_gating
  import sd_clock_pkg::*;
#(
  parameter int SETTLE_CYCLES = INT_SETTLE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        base_clk,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        card_inserted,
  output logic             sdclk,
  output logic             internal_clock_run
);

  typedef logic [FREQ_SEL_WIDTH-1:0] freq_type;

  // Register decode, shared by read and write paths
  function automatic reg_sel_type decode(input logic [11:0] addr);
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr == CLOCK_CONTROL_OFFSET) begin
      sel = SEL_CONTROL;
    end else if (addr == STATUS_OFFSET) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction : decode

  // ---------------- sys_clk domain ----------------
  logic        int_en;
  logic        card_en;
  freq_type    freq_sel;
  freq_type    xfer_freq;
  logic        req_tgl;
  logic        bad_addr;
  logic        next_int_en;
  logic        next_card_en;
  freq_type    next_freq_sel;
  freq_type    next_xfer_freq;
  logic        next_req_tgl;
  logic        next_bad_addr;
  logic [31:0] next_prdata;
  logic        card_present;
  logic [2:0]  back_sync;
  logic        ack_s;
  logic        int_stable_s;
  logic        card_stable_s;
  logic        int_stable_flag;
  logic        card_stable_flag;
  logic        busy;
  logic        pending;
  logic        wr_access;
  reg_sel_type sel;
  logic        ack_tgl;        // Base side, read here only through u_back_sync
  logic        card_stable_b;
  logic        int_stable_b;
  // Card detect is on sys_clk, so gating the internal clock cannot blind it
  bit_sync #(.WIDTH(1)) u_card_sync (
    .clk      (sys_clk),
    .async_in (card_inserted),
    .sync_out (card_present)
  );

  // Flags and acknowledge back from the clock generator
  bit_sync #(.WIDTH(3)) u_back_sync (
    .clk      (sys_clk),
    .async_in ({ack_tgl, card_stable_b, int_stable_b}),
    .sync_out (back_sync)
  );

  assign ack_s         = back_sync[2];
  assign card_stable_s = back_sync[1];
  assign int_stable_s  = back_sync[0];
  // Masking with the enable drops a flag at once, ahead of the slow return path
  assign int_stable_flag  = int_stable_s & int_en;
  assign card_stable_flag = card_stable_s & card_en;
  assign busy      = req_tgl != ack_s;
  assign pending   = busy | (freq_sel != xfer_freq);
  assign sel       = decode(paddr);
  assign wr_access = psel & penable & pwrite;
  // Zero wait states; error only for an unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & bad_addr;
  // Register writes, hardware clear and divider handoff
  always_comb begin
    next_int_en    = int_en;
    next_card_en   = card_en;
    next_freq_sel  = freq_sel;
    next_xfer_freq = xfer_freq;
    next_req_tgl   = req_tgl;
    if (wr_access && sel == SEL_CONTROL) begin
      if (pstrb[0]) begin
        next_int_en  = pwdata[INT_EN_BIT];
        next_card_en = pwdata[CARD_EN_BIT];
      end
      if (pstrb[1]) begin
        next_freq_sel = pwdata[FREQ_SEL_LSB +: FREQ_SEL_WIDTH];
      end
    end
    // Removal beats a software set in the same cycle
    if (!card_present) begin
      next_card_en = 1'b0;
    end
    // Word handoff: data held until the generator acknowledges
    if (!busy && freq_sel != xfer_freq) begin
      next_xfer_freq = freq_sel;
      next_req_tgl   = ~req_tgl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      int_en    <= ENABLE_RESET;
      card_en   <= ENABLE_RESET;
      freq_sel  <= FREQ_SEL_RESET;
      xfer_freq <= FREQ_SEL_RESET;
      req_tgl   <= 1'b0;
    end else begin
      int_en    <= next_int_en;
      card_en   <= next_card_en;
      freq_sel  <= next_freq_sel;
      xfer_freq <= next_xfer_freq;
      req_tgl   <= next_req_tgl;
    end
  end

  // Read data captured in the setup cycle, held through the access phase
  always_comb begin
    next_prdata   = prdata;
    next_bad_addr = bad_addr;
    if (psel && !penable) begin
      next_prdata   = 32'h0000_0000;
      next_bad_addr = sel == SEL_NONE;
      if (!pwrite) begin
        unique case (sel)
          SEL_CONTROL: begin
            next_prdata[INT_EN_BIT]      = int_en;
            next_prdata[INT_STABLE_BIT]  = int_stable_flag;
            next_prdata[CARD_EN_BIT]     = card_en;
            next_prdata[CARD_STABLE_BIT] = card_stable_flag;
            next_prdata[FREQ_SEL_LSB +: FREQ_SEL_WIDTH] = freq_sel;
          end
          SEL_STATUS: begin
            next_prdata[STATUS_CARD_BIT]    = card_present;
            next_prdata[STATUS_PENDING_BIT] = pending;
          end
          SEL_NONE: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata   <= 32'h0000_0000;
      bad_addr <= 1'b0;
    end else begin
      prdata   <= next_prdata;
      bad_addr <= next_bad_addr;
    end
  end

  // ---------------- base_clk domain ----------------
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);
  localparam logic [1:0]  EDGE_LAST   = 2'(CARD_SETTLE_EDGES);
  logic          rst_b;
  logic [2:0]    fwd_sync;
  logic          int_en_b;
  logic          card_en_b;
  logic          req_b;
  logic          run;
  freq_type      half;
  clk_state_type clk_state;
  clk_state_type next_clk_state;
  freq_type      cnt;
  freq_type      next_cnt;
  freq_type      freq_active;
  freq_type      next_freq_active;
  logic          next_ack_tgl;
  logic          sdclk_q;
  logic          next_sdclk_q;
  logic [1:0]    edge_cnt;
  logic [1:0]    next_edge_cnt;
  logic          next_card_stable_b;
  logic [15:0]   settle_cnt;
  logic [15:0]   next_settle_cnt;
  logic          next_int_stable_b;
  logic          run_q;
  logic          next_run_q;

  bit_sync #(.WIDTH(1)) u_reset_sync (
    .clk      (base_clk),
    .async_in (reset),
    .sync_out (rst_b)
  );
  bit_sync #(.WIDTH(3)) u_fwd_sync (
    .clk      (base_clk),
    .async_in ({req_tgl, card_en, int_en}),
    .sync_out (fwd_sync)
  );

  assign req_b     = fwd_sync[2];
  assign card_en_b = fwd_sync[1];
  assign int_en_b  = fwd_sync[0];
  // Card clock needs a settled internal clock even if software jumps ahead
  assign run  = card_en_b & int_stable_b;
  // Setting 0 cannot divide by one in logic; it gives half the base rate
  assign half = (freq_active == '0) ? freq_type'(1) : freq_active;
  assign sdclk              = sdclk_q;
  assign internal_clock_run = run_q;
  // Internal clock gate and settle counter
  always_comb begin
    next_run_q        = int_en_b;
    next_settle_cnt   = settle_cnt;
    next_int_stable_b = int_stable_b;
    if (!int_en_b) begin
      next_settle_cnt   = '0;
      next_int_stable_b = 1'b0;
    end else if (settle_cnt == SETTLE_LAST) begin
      next_int_stable_b = 1'b1;
    end else begin
      next_settle_cnt = settle_cnt + 16'h0001;
    end
  end

  always_ff @(posedge base_clk) begin
    if (rst_b) begin
      run_q        <= 1'b0;
      settle_cnt   <= 16'h0000;
      int_stable_b <= 1'b0;
    end else begin
      run_q        <= next_run_q;
      settle_cnt   <= next_settle_cnt;
      int_stable_b <= next_int_stable_b;
    end
  end

  // Card clock generator: finishes a high half unless the internal clock is lost, and parks low
  always_comb begin
    next_clk_state     = clk_state;
    next_cnt           = cnt;
    next_sdclk_q       = sdclk_q;
    next_freq_active   = freq_active;
    next_ack_tgl       = ack_tgl;
    next_edge_cnt      = edge_cnt;
    next_card_stable_b = card_stable_b;
    unique case (clk_state)
      CLK_STOPPED: begin
        next_sdclk_q = 1'b0;
        next_edge_cnt = 2'b00;
        if (req_b != ack_tgl) begin
          next_freq_active = xfer_freq;
          next_ack_tgl     = req_b;
        end else if (run) begin
          next_clk_state = CLK_LOW;
          next_cnt       = '0;
        end
      end
      CLK_LOW: begin
        if (!run || !int_en_b) begin  // No new high half once the gate closes
          next_clk_state = CLK_STOPPED;
        end else if (cnt == half - freq_type'(1)) begin
          next_clk_state = CLK_HIGH;
          next_cnt       = '0;
          next_sdclk_q   = 1'b1;
          if (edge_cnt != EDGE_LAST) begin
            next_edge_cnt = edge_cnt + 2'b01;
          end
        end else begin
          next_cnt = cnt + freq_type'(1);
        end
      end
      CLK_HIGH: begin
        // Losing the internal clock cuts the high half short
        if (!int_en_b || cnt == half - freq_type'(1)) begin
          next_clk_state = CLK_LOW;
          next_cnt       = '0;
          next_sdclk_q   = 1'b0;
        end else begin
          next_cnt = cnt + freq_type'(1);
        end
      end
    endcase
    if (!run) begin
      next_card_stable_b = 1'b0;
    end else if (edge_cnt == EDGE_LAST) begin
      next_card_stable_b = 1'b1;
    end
  end

  always_ff @(posedge base_clk) begin
    if (rst_b) begin
      clk_state     <= CLK_STOPPED;
      cnt           <= '0;
      sdclk_q       <= 1'b0;
      freq_active   <= FREQ_SEL_RESET;
      ack_tgl       <= 1'b0;
      edge_cnt      <= 2'b00;
      card_stable_b <= 1'b0;
    end else begin
      clk_state     <= next_clk_state;
      cnt           <= next_cnt;
      sdclk_q       <= next_sdclk_q;
      freq_active   <= next_freq_active;
      ack_tgl       <= next_ack_tgl;
      edge_cnt      <= next_edge_cnt;
      card_stable_b <= next_card_stable_b;
    end
  end

endmodule : sd_host_clock_gating

// ---- tb/sd_clock_props.sv ----
// Purpose: Port-level checks of the SD clock gating block.
// Assumes: Control word at 0x000, status word at 0x004.
// Notes:   Sys-side and base-side properties each name their own clock.
module sd_clock_props
  import sd_clock_pkg::*;
#(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        base_clk,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        card_inserted,
  input wire logic        sdclk,
  input wire logic        internal_clock_run
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] same_cnt;
  logic [3:0] next_same_cnt;
  logic       card_prev;
  logic       rd_acc;
  // Cycles the card pin held its level; saturates to avoid wrap
  always_comb begin
    next_same_cnt = (card_inserted != card_prev) ? 4'h0 :
                    ((same_cnt == 4'hF) ? same_cnt : same_cnt + 4'h1);
  end
  always_ff @(posedge sys_clk) begin
    same_cnt  <= reset ? 4'h0 : next_same_cnt;
    card_prev <= card_inserted;
  end
  assign rd_acc = psel && penable && !pwrite;
  // Read access phases of the two words
  sequence s_ctrl_rd;
    rd_acc && paddr == CLOCK_CONTROL_OFFSET;
  endsequence
  sequence s_stat_rd;
    rd_acc && paddr == STATUS_OFFSET && same_cnt > 4'h4;
  endsequence
  property p_card_flag_order;
    @(posedge sys_clk) disable iff (reset) s_ctrl_rd ##0 prdata[3] |-> prdata[2];
  endproperty
  a_card_flag_order: assert property (p_card_flag_order)
    else $error("card stable flag without card enable");
  property p_int_flag_order;
    @(posedge sys_clk) disable iff (reset) s_ctrl_rd ##0 prdata[1] |-> prdata[0];
  endproperty
  a_int_flag_order: assert property (p_int_flag_order)
    else $error("internal stable flag without internal enable");
  property p_absent_card_off;
    @(posedge sys_clk) disable iff (reset)
      s_ctrl_rd ##0 (!card_inserted && same_cnt > 4'h4) |-> !prdata[2];
  endproperty
  a_absent_card_off: assert property (p_absent_card_off)
    else $error("card enable set with no card");
  property p_status_follows;
    @(posedge sys_clk) disable iff (reset) s_stat_rd |-> prdata[0] == card_inserted;
  endproperty
  a_status_follows: assert property (p_status_follows)
    else $error("card status does not follow pin");
  property p_unmapped_err;
    @(posedge sys_clk) disable iff (reset)
      psel && penable && paddr != CLOCK_CONTROL_OFFSET && paddr != STATUS_OFFSET
      |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");
  property p_err_in_access;
    @(posedge sys_clk) disable iff (reset) pslverr |-> psel && penable;
  endproperty
  a_err_in_access: assert property (p_err_in_access)
    else $error("error response outside access phase");
  property p_sdclk_needs_run;
    @(posedge base_clk) disable iff (reset) $rose(sdclk) |-> internal_clock_run;
  endproperty
  a_sdclk_needs_run: assert property (p_sdclk_needs_run)
    else $error("card clock runs without internal clock");
  property p_run_cut_low;
    @(posedge base_clk) disable iff (reset) $fell(internal_clock_run) |-> ##[0:1] !sdclk;
  endproperty
  a_run_cut_low: assert property (p_run_cut_low)
    else $error("card clock not cut with internal clock");
  property p_stopped_low;
    @(posedge base_clk) disable iff (reset) !internal_clock_run && !sdclk |=> !sdclk;
  endproperty
  a_stopped_low: assert property (p_stopped_low)
    else $error("stopped card clock left low level");
endmodule : sd_clock_props

bind sd_host_clock_gating sd_clock_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) props_u (
  .sys_clk, .reset, .base_clk, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .card_inserted, .sdclk, .internal_clock_run);

// ---- tb/card_model.sv ----
// Purpose: Card side: presence pin, clock edge count, high-half width.
// Assumes: Card clock changes only on base clock rising edges.
// Notes:   Width is sampled on falling base edges to stay clear of races.
module card_model (
  input  wire logic base_clk,
  input  wire logic sdclk,
  input  wire logic present_cmd,
  output logic      card_inserted,
  output int        rise_count,
  output int        high_width
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  int rises = 0;
  int width = 0;
  // Outputs mirror the counters so each has a single driver
  assign rise_count = rises;
  assign high_width = width;
  // Presence pin level, insertion and removal on command
  assign card_inserted = present_cmd;
  always @(posedge sdclk) begin
    rises <= rises + 1;
  end
  // Length of the last high half in base cycles
  always @(negedge base_clk) begin
    if (sdclk) begin
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule : card_model

// ---- tb/sd_host_clock_gating_tb.sv ----
// Purpose: Self-checking bench of the SD clock gating block.
// Assumes: Zero-wait APB slave, shortened settle count.
// Notes:   Reads from rd_chk note their expectation; a monitor compares on completion.
module sd_host_clock_gating_tb;
  import sd_clock_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  logic        sys_clk, reset, base_clk, psel, penable, pwrite, present_cmd;
  logic        pready, pslverr, card_inserted, sdclk, internal_clock_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [32:0] exp_q[$];
  logic [32:0] mask_q[$];
  int          rise_count, high_width, err_count, num_checks, n, f;
  sd_host_clock_gating #(.SETTLE_CYCLES(SETTLE)) dut_u (.sys_clk, .reset, .base_clk,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .card_inserted, .sdclk, .internal_clock_run);
  card_model card_u (.base_clk, .sdclk, .present_cmd, .card_inserted, .rise_count,
    .high_width);
  // Clocks with unrelated phase
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    base_clk = 1'b0;
    #7;
    forever #40 base_clk = ~base_clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One APB transfer; idles a cycle so strobes never toggle twice at one edge
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      final_report();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [31:0] d);
    apb(CLOCK_CONTROL_OFFSET, 1'b1, d, rd);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    apb(a, 1'b0, 32'h0, rd);
  endtask : rd_chk
  // Poll the control word until a flag reads 1, bounded
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && k < 200) begin
      apb(CLOCK_CONTROL_OFFSET, 1'b0, 32'h0, rd);
      k++;
    end
    if (k >= 200) begin
      err_count++;
      final_report();
    end
  endtask : wait_bit
  // Monitor: each completed read with a note waiting meets the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() != 0) begin
      check("read", {pslverr, prdata} & mask_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
  end
  // Main sequence; reset held long enough for the base side to see it
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    present_cmd = 1'b1;
    reset = 1'b1;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'h2DEE970A));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h100, ~33'h0);
    rd_chk(STATUS_OFFSET, 33'h1, 33'h100000001);
    rd_chk(12'h008, 33'h100000000, ~33'h0);
    wr(32'h101);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h101, ~33'h0);
    wait_bit(INT_STABLE_BIT);
    check("run", {32'h0, internal_clock_run}, 33'h1);
    n = rise_count;
    wr(32'h105);
    wait_bit(CARD_STABLE_BIT);
    check("edges", {32'h0, rise_count >= n + 2}, 33'h1);
    // Disable: card bits drop at once, clock parks low
    wr(32'h101);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h103, ~33'h0);
    repeat (20) @(posedge sys_clk);
    n = rise_count;
    repeat (20) @(posedge sys_clk);
    check("parked", {31'h0, sdclk, rise_count == n}, 33'h1);
    // Random divider set while stopped, applied on restart
    f = ($urandom % 4) + 1;
    wr(32'h1 | (32'(f) << 8));
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h3 | (33'(f) << 8), ~33'h0);
    wr(32'h5 | (32'(f) << 8));
    wait_bit(CARD_STABLE_BIT);
    repeat (40) @(posedge sys_clk);
    check("half", 33'(high_width), 33'(f));
    // Internal clock off: registers usable, detection alive
    wr(32'h500);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h500, ~33'h0);
    repeat (10) @(posedge sys_clk);
    check("run_off", {32'h0, internal_clock_run}, 33'h0);
    present_cmd <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd_chk(STATUS_OFFSET, 33'h0, 33'h1);
    present_cmd <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wr(32'h501);
    wait_bit(INT_STABLE_BIT);
    wr(32'h505);
    wait_bit(CARD_STABLE_BIT);
    // Removal while running clears the enable; later sets refused
    present_cmd <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h503, ~33'h0);
    wr(32'h505);
    rd_chk(CLOCK_CONTROL_OFFSET, 33'h503, ~33'h0);
    final_report();
  end
endmodule : sd_host_clock_gating_tb
